/* File: lific_params.svh */
// Constants and timing counts of the lamp inverter fault controller.
// Assumes a 20 MHz clock and comparator outputs synchronous to it.
`ifndef LIFIC_PARAMS_SVH
`define LIFIC_PARAMS_SVH
`define LIFIC_CLK_MHZ 20
`define LIFIC_DISCH_NS 600
`define LIFIC_DISCH_CYC ((`LIFIC_DISCH_NS * `LIFIC_CLK_MHZ) / 1000)
`define LIFIC_EVT_W 4
`define LIFIC_WDG_W 9
`define LIFIC_SHORT_W 7
`define LIFIC_BURST_W 8
`define LIFIC_HALF_W 8
`define LIFIC_HALF_DEF 8'h10
`endif

/* File: lific_pkg.sv */
// Types shared by the lamp inverter fault controller files.
// Assumes nothing outside itself.
package lific_pkg;
  // Gray coded states along idle, strike, run, fault.
  typedef enum logic [1:0] {
    LIFIC_IDLE = 2'b00,
    LIFIC_STRIKE = 2'b01,
    LIFIC_RUN = 2'b11,
    LIFIC_FAULT = 2'b10
  } lific_state_e;

  // Dimming method picked by the brightness inputs.
  typedef enum logic [1:0] {
    LIFIC_DIM_NONE = 2'b00,
    LIFIC_DIM_ANALOG = 2'b01,
    LIFIC_DIM_BURST = 2'b10,
    LIFIC_DIM_BOTH = 2'b11
  } lific_dim_e;
endpackage

/* File: lific_bridge.sv */
// Full bridge gate phase generator of the lamp inverter.
// Assumes a run enable from the sequencer; outputs go straight to drivers.
`timescale 1ns/1ps
`default_nettype none
`include "lific_params.svh"
module lific_bridge #(
  parameter int HALF_W = `LIFIC_HALF_W
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic run_i,
  input wire logic [HALF_W-1:0] half_i,
  // Gates.
  output logic n_a_o,
  output logic n_b_o,
  output logic p_c_o,
  output logic p_d_o
);
  typedef struct packed {
    logic [HALF_W-1:0] cnt;
    logic phase;
    logic n_a;
    logic n_b;
    logic p_c;
    logic p_d;
  } lific_br_s;
  lific_br_s st, next_st;

  // Half period counter toggles phase; a dead cycle at each turn avoids
  // shoot through since both legs fall idle before the other pair starts.
  always_comb begin
    next_st = st;
    if (!run_i) begin
      next_st.cnt = '0;
      next_st.n_a = 1'b0;
      next_st.n_b = 1'b0;
      next_st.p_c = 1'b1;
      next_st.p_d = 1'b1;
    end else begin
      if (st.cnt >= half_i) begin
        next_st.cnt = '0;
        next_st.phase = ~st.phase;
        next_st.n_a = 1'b0;
        next_st.n_b = 1'b0;
        next_st.p_c = 1'b1;
        next_st.p_d = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
        next_st.n_a = st.phase;
        next_st.p_d = st.phase;
        next_st.n_b = ~st.phase;
        next_st.p_c = ~st.phase;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{cnt: '0, phase: 1'b0, n_a: 1'b0, n_b: 1'b0,
              p_c: 1'b1, p_d: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign n_a_o = st.n_a;
  assign n_b_o = st.n_b;
  assign p_c_o = st.p_c;
  assign p_d_o = st.p_d;
endmodule
`default_nettype wire

/* File: lific_top.sv */
// Strike and run sequencer with latched fault supervision.
// Assumes comparator pulses are one cycle wide and synchronous to clk_i;
// the analog thresholds are realised outside and select which pulse arrives.
`timescale 1ns/1ps
`default_nettype none
`include "lific_params.svh"
module lific_top
  import lific_pkg::*;
#(
  parameter int EVT_W = `LIFIC_EVT_W,
  parameter int WDG_W = `LIFIC_WDG_W,
  parameter int SHORT_W = `LIFIC_SHORT_W,
  parameter int BURST_W = `LIFIC_BURST_W,
  parameter int HALF_W = `LIFIC_HALF_W,
  parameter logic [HALF_W-1:0] FIX_HALF = `LIFIC_HALF_DEF,
  parameter logic [HALF_W-1:0] TRK_START = `LIFIC_HALF_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Supply and enable.
  input wire logic enable_i,
  input wire logic supply_good_i,
  // Lamp current comparator pulses.
  input wire logic cur_strike_pk_i,
  input wire logic cur_run_pk_i,
  // Lamp voltage comparator pulses and levels.
  input wire logic volt_over_pk_i,
  input wire logic volt_zero_cross_i,
  input wire logic volt_low_i,
  input wire logic volt_pk_i,
  // Return current comparator pulse.
  input wire logic ret_over_pk_i,
  // Timers and burst dimming.
  input wire logic strike_timeout_i,
  input wire logic timeout_cap_above_i,
  input wire logic burst_ramp_cycle_i,
  input wire logic burst_ramp_clock_i,
  input wire logic burst_off_i,
  // Brightness inputs tied to the internal supply.
  input wire logic analog_tied_high_i,
  input wire logic burst_tied_high_i,
  // Tracking loop step request from the resonance detector.
  input wire logic track_up_i,
  // Gate drives.
  output logic n_gate_a_o,
  output logic n_gate_b_o,
  output logic p_gate_c_o,
  output logic p_gate_d_o,
  // Status and analog steering.
  output logic strike_o,
  output logic run_o,
  output logic fault_o,
  output logic ignited_o,
  output logic low_threshold_o,
  output logic track_loop_o,
  output logic comp_clamp_o,
  output logic comp_discharge_o,
  output logic [1:0] dim_mode_o
);
  import lific_pkg::*;

  localparam int DISCH_CYC = `LIFIC_DISCH_CYC;
  localparam logic [4:0] DISCH_LOAD = 5'(DISCH_CYC);

  typedef struct packed {
    lific_state_e state;
    logic strike;
    logic run;
    logic fault;
    logic clamp;
    logic disch_on;
    logic ignited;
    logic swept;
    logic [HALF_W-1:0] half;
    logic [EVT_W-1:0] evt;
    logic [WDG_W-1:0] wdg;
    logic [SHORT_W-1:0] shrt;
    logic [BURST_W-1:0] brst;
    logic [4:0] disch;
    logic [1:0] dim;
  } lific_top_s;

  lific_top_s st, next_st;
  logic bridge_run;
  logic trip;

  // Returns one when a counter of up to 16 bits is at all ones.
  function automatic logic at_top(input logic [15:0] v, input int w);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i < w && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // Sequencer, counters and fault latch.
  always_comb begin
    logic live;
    live = 1'b0;
    trip = 1'b0;
    next_st = st;
    live = (st.state == LIFIC_STRIKE) || (st.state == LIFIC_RUN);
    // Dimming mode tracks the straps: a tied input disables its method.
    next_st.dim = {~burst_tied_high_i, ~analog_tied_high_i};
    // Compensation discharge timer restarts on every over voltage peak.
    if (volt_over_pk_i) begin
      next_st.disch = DISCH_LOAD;
    end else if (st.disch != '0) begin
      next_st.disch = st.disch - 1'b1;
    end
    // Event counter: ramp clear first, then count, so a clear in the same
    // cycle as an event still leaves that event counted.
    if (burst_ramp_cycle_i) begin
      next_st.evt = '0;
    end
    if (live && (volt_over_pk_i || ret_over_pk_i)) begin
      if (at_top(16'(st.evt), EVT_W)) begin
        trip = 1'b1;
      end
      next_st.evt = (burst_ramp_cycle_i ? '0 : st.evt) + 1'b1;
    end
    // Short lamp counter: low voltage blocks its reset.
    if (live && timeout_cap_above_i) begin
      if (volt_pk_i && !volt_low_i) begin
        next_st.shrt = '0;
      end else if (at_top(16'(st.shrt), SHORT_W)) begin
        trip = 1'b1;
      end else begin
        next_st.shrt = st.shrt + 1'b1;
      end
    end else begin
      next_st.shrt = '0;
    end
    // Run watchdogs on lamp current.
    if (st.state == LIFIC_RUN) begin
      if (cur_run_pk_i) begin
        next_st.wdg = '0;
        next_st.brst = '0;
      end else if (!burst_off_i) begin
        if (at_top(16'(st.wdg), WDG_W)) begin
          trip = 1'b1;
        end else begin
          next_st.wdg = st.wdg + 1'b1;
        end
        if (burst_ramp_clock_i) begin
          if (at_top(16'(st.brst), BURST_W)) begin
            trip = 1'b1;
          end else begin
            next_st.brst = st.brst + 1'b1;
          end
        end
      end
    end else begin
      next_st.wdg = '0;
      next_st.brst = '0;
    end
    // Tracking loop sweeps up only after the first zero crossing.
    if (volt_zero_cross_i) begin
      next_st.swept = 1'b1;
    end
    if (st.state == LIFIC_STRIKE && st.swept && track_up_i &&
        st.half > 1) begin
      next_st.half = st.half - 1'b1;
    end
    // State transitions.
    case (st.state)
      LIFIC_IDLE: begin
        if (supply_good_i && enable_i) begin
          next_st.state = LIFIC_STRIKE;
          next_st.half = TRK_START;
          next_st.swept = 1'b0;
          next_st.ignited = 1'b0;
          next_st.evt = '0;
        end
      end
      LIFIC_STRIKE: begin
        if (trip || strike_timeout_i) begin
          next_st.state = LIFIC_FAULT;
        end else if (cur_strike_pk_i) begin
          next_st.ignited = 1'b1;
          next_st.state = LIFIC_RUN;
          next_st.half = FIX_HALF;
        end
      end
      LIFIC_RUN: begin
        if (trip) begin
          next_st.state = LIFIC_FAULT;
        end
      end
      default: begin
        next_st.state = LIFIC_FAULT;
      end
    endcase
    // Only an enable cycle or power loss leaves the latched fault.
    if (!enable_i || !supply_good_i) begin
      next_st.state = LIFIC_IDLE;
      next_st.ignited = 1'b0;
    end
    // Status flags are decoded from the next state and registered, so
    // every output leaves a flop with no decode glitch behind it.
    next_st.strike = (next_st.state == LIFIC_STRIKE);
    next_st.run = (next_st.state == LIFIC_RUN);
    next_st.fault = (next_st.state == LIFIC_FAULT);
    next_st.clamp = next_st.strike && !next_st.ignited;
    next_st.disch_on = (next_st.disch != '0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{state: LIFIC_IDLE, strike: 1'b0, run: 1'b0, fault: 1'b0,
              clamp: 1'b0, disch_on: 1'b0, ignited: 1'b0, swept: 1'b0,
              half: '0, evt: '0, wdg: '0, shrt: '0, brst: '0,
              disch: '0, dim: 2'h0};
    end else begin
      st <= next_st;
    end
  end

  // Bridge runs only while striking or running; fault leaves it idle.
  assign bridge_run = (st.state == LIFIC_STRIKE) ||
                      (st.state == LIFIC_RUN);

  lific_bridge #(
    .HALF_W(HALF_W)
  ) u_bridge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(bridge_run),
    .half_i(st.half),
    .n_a_o(n_gate_a_o),
    .n_b_o(n_gate_b_o),
    .p_c_o(p_gate_c_o),
    .p_d_o(p_gate_d_o)
  );

  // Status flags come straight from state flops.
  assign strike_o = st.strike;
  assign run_o = st.run;
  assign fault_o = st.fault;
  assign ignited_o = st.ignited;
  assign low_threshold_o = st.ignited;
  assign track_loop_o = st.strike;
  assign comp_clamp_o = st.clamp;
  assign comp_discharge_o = st.disch_on;
  assign dim_mode_o = st.dim;

  // Checks on the sequencing and fault behaviour.
  sequence s_strike_ign;
    st.state == LIFIC_STRIKE && cur_strike_pk_i && !strike_timeout_i &&
    !trip && enable_i && supply_good_i;
  endsequence

  // Bridge live and nothing pending that would force the sequencer idle.
  sequence s_live;
    (strike_o || run_o) && enable_i && supply_good_i;
  endsequence

  property p_enter_strike;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st.state == LIFIC_IDLE && enable_i && supply_good_i) |=>
      strike_o;
  endproperty
  a_enter_strike: assert property (p_enter_strike)
    else $error("Strike not entered after enable.");

  property p_ignite;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_strike_ign |=> (run_o && ignited_o);
  endproperty
  a_ignite: assert property (p_ignite)
    else $error("Ignition did not enter run.");

  property p_fixed_freq;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(run_o) |-> st.half == FIX_HALF;
  endproperty
  a_fixed_freq: assert property (p_fixed_freq)
    else $error("Run did not load fixed frequency.");

  property p_timeout;
    @(posedge clk_i) disable iff (!rst_n_i)
    (strike_o && strike_timeout_i && enable_i && supply_good_i) |=>
      fault_o;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Strike timeout did not fault.");

  property p_latched;
    @(posedge clk_i) disable iff (!rst_n_i)
    (fault_o && enable_i && supply_good_i) |=> fault_o;
  endproperty
  a_latched: assert property (p_latched)
    else $error("Fault released without enable cycle.");

  property p_disch;
    @(posedge clk_i) disable iff (!rst_n_i)
    volt_over_pk_i |=> comp_discharge_o [*8] ##1 comp_discharge_o [*4];
  endproperty
  a_disch: assert property (p_disch)
    else $error("Compensation discharge too short.");

  property p_clamp;
    @(posedge clk_i) disable iff (!rst_n_i)
    strike_o |-> comp_clamp_o;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Compensation not clamped in strike.");

  property p_gates_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (fault_o && $past(fault_o)) |->
      (!n_gate_a_o && !n_gate_b_o && p_gate_c_o && p_gate_d_o);
  endproperty
  a_gates_off: assert property (p_gates_off)
    else $error("Bridge conducting during fault.");

  property p_no_supply;
    @(posedge clk_i) disable iff (!rst_n_i)
    !supply_good_i |=> ##1 (!n_gate_a_o && !n_gate_b_o);
  endproperty
  a_no_supply: assert property (p_no_supply)
    else $error("N gates on without supply.");

  property p_threshold;
    @(posedge clk_i) disable iff (!rst_n_i)
    run_o |-> low_threshold_o;
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("Low threshold not applied in run.");

  property p_evt_trip;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_live ##0 (st.evt == '1 && (volt_over_pk_i || ret_over_pk_i)) |=>
      fault_o;
  endproperty
  a_evt_trip: assert property (p_evt_trip)
    else $error("Sixteenth counted event did not fault.");

  property p_wdg_trip;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_live ##0 (run_o && st.wdg == '1 && !cur_run_pk_i && !burst_off_i) |=>
      fault_o;
  endproperty
  a_wdg_trip: assert property (p_wdg_trip)
    else $error("Watchdog overflow did not fault.");

  property p_short_trip;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_live ##0 (timeout_cap_above_i && st.shrt == '1 &&
                !(volt_pk_i && !volt_low_i)) |=> fault_o;
  endproperty
  a_short_trip: assert property (p_short_trip)
    else $error("Short lamp counter overflow did not fault.");
endmodule
`default_nettype wire

/* File: lific_fet_model.sv */
// Behavioural model of the four power FETs that drive the lamp transformer.
// Assumes gate levels straight from the controller: N on high, P on low.
`timescale 1ns/1ps
`default_nettype none
module lific_fet_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Gate drives.
  input wire logic n_gate_a_i,
  input wire logic n_gate_b_i,
  input wire logic p_gate_c_i,
  input wire logic p_gate_d_i,
  // Observation.
  output logic conduct_o,
  output logic [7:0] toggles_o
);
  logic last_a;

  // An unknown gate counts as on, so a floating drive cannot pass as off.
  assign conduct_o = (n_gate_a_i !== 1'b0) | (n_gate_b_i !== 1'b0) |
                     (p_gate_c_i !== 1'b1) | (p_gate_d_i !== 1'b1);

  // Edges on the A leg show that the oscillator really switches the bridge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_a <= 1'b0;
      toggles_o <= 8'h00;
    end else begin
      last_a <= n_gate_a_i;
      if ((last_a != n_gate_a_i) && (toggles_o != 8'hFF)) begin
        toggles_o <= toggles_o + 8'h01; // Saturates rather than wraps.
      end
    end
  end
endmodule
`default_nettype wire

/* File: lific_tb.sv */
// Self-checking bench of the lamp inverter fault controller.
// Assumes the FET model is compiled first; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lific_pkg::*;
  localparam int WDG = 10; // Wider watchdog lets the burst counter win.
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic enable_i = 1'b0, supply_good_i = 1'b0, volt_low_i = 1'b0;
  logic strike_timeout_i = 1'b0, timeout_cap_above_i = 1'b0;
  logic burst_off_i = 1'b0, analog_tied_i = 1'b0, burst_tied_i = 1'b0;
  logic [8:0] pk = 9'h000;
  logic n_a, n_b, p_c, p_d, strike_o, run_o, fault_o, ignited_o;
  logic low_thr, track_o, clamp_o, disch_o, conduct;
  logic [1:0] dim_mode_o;
  logic [7:0] toggles;
  logic hit;
  int n_errors = 0;
  int checks = 0;
  int n;

  // Half period of 25 ns gives the 20 MHz clock.
  always #25 clk_i = ~clk_i;

  lific_top #(.WDG_W(WDG)) u_lific_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .supply_good_i(supply_good_i), .cur_strike_pk_i(pk[0]),
    .cur_run_pk_i(pk[1]), .volt_over_pk_i(pk[2]),
    .volt_zero_cross_i(pk[3]), .volt_low_i(volt_low_i), .volt_pk_i(pk[4]),
    .ret_over_pk_i(pk[5]), .strike_timeout_i(strike_timeout_i),
    .timeout_cap_above_i(timeout_cap_above_i),
    .burst_ramp_cycle_i(pk[6]), .burst_ramp_clock_i(pk[7]),
    .burst_off_i(burst_off_i), .analog_tied_high_i(analog_tied_i),
    .burst_tied_high_i(burst_tied_i), .track_up_i(pk[8]),
    .n_gate_a_o(n_a), .n_gate_b_o(n_b), .p_gate_c_o(p_c),
    .p_gate_d_o(p_d), .strike_o(strike_o), .run_o(run_o),
    .fault_o(fault_o), .ignited_o(ignited_o), .low_threshold_o(low_thr),
    .track_loop_o(track_o), .comp_clamp_o(clamp_o),
    .comp_discharge_o(disch_o), .dim_mode_o(dim_mode_o)
  );

  lific_fet_model u_lific_fet_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .n_gate_a_i(n_a), .n_gate_b_i(n_b),
    .p_gate_c_i(p_c), .p_gate_d_i(p_d), .conduct_o(conduct),
    .toggles_o(toggles)
  );

  // Verdict and end of run; also the exit of every exhausted wait.
  task automatic finish_test();
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask

  // One-cycle comparator pulse on the selected line, then idle cycles.
  task automatic pulse(input int sel, input int gap);
    @(negedge clk_i);
    pk[sel] = 1'b1;
    @(negedge clk_i);
    pk = 9'h000;
    repeat (gap) @(negedge clk_i);
  endtask

  // Bounded wait for the fault latch; a miss ends the run.
  task automatic wait_fault(input int max);
    hit = 1'b0;
    for (int i = 0; i < max && !hit; i++) begin
      @(negedge clk_i);
      hit = (fault_o === 1'b1);
    end
    if (!hit) begin
      n_errors++;
      $display("unexpected fault_o: expected 1, seen %b", fault_o);
      finish_test();
    end
  endtask

  // Enable cycling clears any fault and starts a new strike.
  task automatic restart();
    enable_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("fault_o", fault_o, 8'h00);
    enable_i = 1'b1;
    @(negedge clk_i);
    check("strike_o", strike_o, 8'h01);
  endtask

  task automatic t_reset();
    check("gates", {n_a, n_b, p_c, p_d}, 8'h03);
    rst_n_i = 1'b1;
    enable_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("gates", {n_a, n_b, p_c, p_d}, 8'h03);
    supply_good_i = 1'b1;
  endtask

  task automatic t_strike();
    restart();
    check("comp_clamp_o", clamp_o, 8'h01);
    check("track_loop_o", track_o, 8'h01);
    check("low_threshold_o", low_thr, 8'h00);
    pulse(3, 2);
    pulse(8, 40);
    check("toggles", toggles !== 8'h00, 8'h01);
    pulse(0, 0);
    check("run_ignited", {run_o, ignited_o, strike_o}, 8'h06);
    check("low_threshold_o", low_thr, 8'h01);
    check("track_loop_o", track_o, 8'h00);
    check("comp_clamp_o", clamp_o, 8'h00);
  endtask

  task automatic t_events();
    restart();
    pulse(2, 0);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      if (disch_o === 1'b1) n++;
      @(negedge clk_i);
    end
    check("discharge_cycles", n[7:0], 8'h0C);
    for (int i = 0; i < 14; i++) pulse(2, 1);
    check("fault_o", fault_o, 8'h00);
    pulse(6, 1);
    for (int i = 0; i < 15; i++) pulse(5, 1);
    check("fault_o", fault_o, 8'h00);
    pulse(5, 0);
    wait_fault(4);
    repeat (100) @(negedge clk_i);
    check("fault_o", fault_o, 8'h01);
    check("gates", {n_a, n_b, p_c, p_d}, 8'h03);
    check("conduct", conduct, 8'h00);
  endtask

  task automatic t_timeout();
    restart();
    strike_timeout_i = 1'b1;
    wait_fault(4);
    strike_timeout_i = 1'b0;
  endtask

  task automatic t_watchdog();
    restart();
    pulse(0, 0);
    for (int i = 0; i < 3; i++) pulse(1, 800);
    check("fault_o", fault_o, 8'h00);
    burst_off_i = 1'b1;
    repeat (1200) @(negedge clk_i);
    check("fault_o", fault_o, 8'h00);
    burst_off_i = 1'b0;
    pulse(1, (1 << WDG) - 20);
    check("fault_o", fault_o, 8'h00);
    wait_fault(40);
  endtask

  task automatic t_burst();
    restart();
    pulse(0, 0);
    pulse(1, 0);
    for (int i = 0; i < 255; i++) pulse(7, 0);
    check("fault_o", fault_o, 8'h00);
    pulse(7, 0);
    wait_fault(4);
  endtask

  task automatic t_short();
    restart();
    volt_low_i = 1'b1;
    repeat (300) @(negedge clk_i);
    check("fault_o", fault_o, 8'h00);
    timeout_cap_above_i = 1'b1;
    volt_low_i = 1'b0;
    for (int i = 0; i < 6; i++) pulse(4, 60);
    check("fault_o", fault_o, 8'h00);
    volt_low_i = 1'b1;
    for (int i = 0; i < 3; i++) pulse(4, 38);
    wait_fault(30);
    volt_low_i = 1'b0;
    timeout_cap_above_i = 1'b0;
  endtask

  task automatic t_dim();
    for (int i = 0; i < 4; i++) begin
      {burst_tied_i, analog_tied_i} = i[1:0];
      repeat (2) @(negedge clk_i);
      check("dim_mode_o", dim_mode_o, {6'h00, ~i[1:0]});
    end
  endtask

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    repeat (6) @(negedge clk_i);
    t_reset();
    t_strike();
    t_events();
    t_timeout();
    t_watchdog();
    t_burst();
    t_short();
    t_dim();
    finish_test();
  end
endmodule
`default_nettype wire
